// ==== common/iod_pkg.sv ====
// ==========================================================
// Shared constants for the I/O space access decoder
package iod_pkg;

    // ==========================================================
    // Processor access kinds
    typedef enum logic [2:0] {
        OP_IO_READ,
        OP_IO_WRITE,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_SKIP_IF_SET,
        OP_SKIP_IF_CLEAR,
        OP_DATA_LOAD,
        OP_DATA_STORE
    } iod_op_t;

    // ==========================================================
    // Address map
    localparam int          IO_COUNT       = 64;
    localparam logic [5:0]  IO_BIT_LAST    = 6'h1F;
    localparam logic [7:0]  DATA_IO_OFFSET = 8'h20;
    localparam logic [7:0]  EXT_FIRST      = 8'h60;
    localparam logic [5:0]  FLAG_IO_ADDR   = 6'h16;
    localparam logic [7:0]  IO_RESET_VAL   = 8'h00;
    localparam logic [7:0]  EXT_RESET_VAL  = 8'h00;

    // ==========================================================
    // Extended register offsets and implemented-bit masks
    localparam int          EXT_COUNT = 13;
    localparam logic [7:0]  ASYNC_TIMER_STATUS_OFS      = 8'hB6;
    localparam logic [7:0]  TWOWIRE_BIT_RATE_OFS        = 8'hB8;
    localparam logic [7:0]  TWOWIRE_STATUS_PRESCALE_OFS = 8'hB9;
    localparam logic [7:0]  TWOWIRE_OWN_ADDRESS_OFS     = 8'hBA;
    localparam logic [7:0]  TWOWIRE_DATA_OFS            = 8'hBB;
    localparam logic [7:0]  TWOWIRE_CONTROL_OFS         = 8'hBC;
    localparam logic [7:0]  TWOWIRE_ADDRESS_MASK_OFS    = 8'hBD;
    localparam logic [7:0]  SERIAL_STATUS_A_OFS         = 8'hC0;
    localparam logic [7:0]  SERIAL_CONTROL_B_OFS        = 8'hC1;
    localparam logic [7:0]  SERIAL_FRAME_CONFIG_OFS     = 8'hC2;
    localparam logic [7:0]  SERIAL_BAUD_LOW_OFS         = 8'hC4;
    localparam logic [7:0]  SERIAL_BAUD_HIGH_OFS        = 8'hC5;
    localparam logic [7:0]  SERIAL_DATA_OFS             = 8'hC6;

    localparam logic [7:0] EXT_ADDR [EXT_COUNT] = '{
        ASYNC_TIMER_STATUS_OFS, TWOWIRE_BIT_RATE_OFS, TWOWIRE_STATUS_PRESCALE_OFS,
        TWOWIRE_OWN_ADDRESS_OFS, TWOWIRE_DATA_OFS, TWOWIRE_CONTROL_OFS,
        TWOWIRE_ADDRESS_MASK_OFS, SERIAL_STATUS_A_OFS, SERIAL_CONTROL_B_OFS,
        SERIAL_FRAME_CONFIG_OFS, SERIAL_BAUD_LOW_OFS, SERIAL_BAUD_HIGH_OFS,
        SERIAL_DATA_OFS};
    localparam logic [7:0] EXT_MASK [EXT_COUNT] = '{
        8'h7F, 8'hFF, 8'hFB, 8'hFF, 8'hFF, 8'hFD, 8'hFE,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF};

endpackage

// ==== src/iod_ext_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Extended I/O register bank, data-space only
module iod_ext_bank (
    // Clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    // Access from decoder
    input  wire logic                                  wr_en,
    input  wire logic [7:0]                            addr,
    input  wire logic [7:0]                            wdata,
    output logic      [7:0]                            rdata,
    output logic                                       hit,
    // Register contents toward peripherals
    output logic      [iod_pkg::EXT_COUNT*8-1:0]       regs_q
);
    import iod_pkg::*;

    logic [7:0]           ext_reg  [EXT_COUNT];
    logic [7:0]           ext_next [EXT_COUNT];
    logic [EXT_COUNT-1:0] match;

    // ==========================================================
    // One register per entry, reserved bits held at zero
    for (genvar i = 0; i < EXT_COUNT; i++) begin : g_ext
        assign match[i] = (addr == EXT_ADDR[i]);
        always_comb begin
            ext_next[i] = ext_reg[i];
            if (wr_en && match[i]) begin
                ext_next[i] = wdata & EXT_MASK[i]; // RQ8
            end
        end
        always_ff @(posedge core_clk) begin
            if (rst) begin
                ext_reg[i] <= EXT_RESET_VAL;
            end else begin
                ext_reg[i] <= ext_next[i];
            end
        end
        assign regs_q[i*8 +: 8] = ext_reg[i];
    end

    // Read mux, unmapped locations read zero
    always_comb begin
        rdata = 8'h00; // RQ8
        for (int k = 0; k < EXT_COUNT; k++) begin
            if (match[k]) begin
                rdata = ext_reg[k];
            end
        end
    end

    assign hit = |match;

endmodule
`default_nettype wire

// ==== src/iod_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] Bit set and clear only reach I/O 0x00-0x1F; higher addresses are refused.
// [RQ2] Skip-if-set and skip-if-clear test one bit of I/O 0x00-0x1F.
// [RQ3] Flag bits clear on a written one; zero leaves them; hardware set wins.
// [RQ4] Bit set or clear touches only the addressed bit, never other flags.
// [RQ5] Dedicated I/O read and write use I/O addresses 0x00-0x3F.
// [RQ6] Data address equal to I/O address plus 0x20 maps onto that register.
// [RQ7] Extended region 0x60-0xFF is reachable only by data load and store.
// [RQ8] Reserved extended locations and bits read zero and ignore writes.
module iod_decoder (
    // Clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    // Processor request
    input  wire logic                                  req_valid,
    input  wire iod_pkg::iod_op_t                      req_op,
    input  wire logic [7:0]                            req_addr,
    input  wire logic [2:0]                            req_bit,
    input  wire logic [7:0]                            req_wdata,
    // Processor response
    output logic                                       rsp_valid,
    output logic      [7:0]                            rsp_rdata,
    output logic                                       rsp_skip,
    output logic                                       rsp_error,
    // Peripheral side
    input  wire logic [7:0]                            flag_set,
    output logic      [7:0]                            flag_q,
    output logic      [iod_pkg::EXT_COUNT*8-1:0]       ext_regs_q
);
    import iod_pkg::*;

    // ==========================================================
    // State
    logic [7:0] io_reg  [IO_COUNT];
    logic [7:0] io_next [IO_COUNT];
    logic       rsp_valid_reg, rsp_valid_next;
    logic [7:0] rsp_rdata_reg, rsp_rdata_next;
    logic       rsp_skip_reg,  rsp_skip_next;
    logic       rsp_error_reg, rsp_error_next;

    logic [5:0] io_idx;
    logic       io_rd, io_wr, bit_wr, bit_tst, ext_rd, ext_wr, bad;
    logic [7:0] io_rd_data, ext_rdata, bit_mask;
    logic       ext_hit, cur_bit;

    // ==========================================================
    // Address decode
    always_comb begin
        io_idx  = req_addr[5:0];
        io_rd   = 1'b0;
        io_wr   = 1'b0;
        bit_wr  = 1'b0;
        bit_tst = 1'b0;
        ext_rd  = 1'b0;
        ext_wr  = 1'b0;
        bad     = 1'b0;
        if (req_valid) begin
            case (req_op)
                OP_IO_READ: begin
                    io_rd = 1'b1; // RQ5
                end
                OP_IO_WRITE: begin
                    io_wr = 1'b1; // RQ5
                end
                OP_BIT_SET, OP_BIT_CLEAR: begin
                    bit_wr = (req_addr[5:0] <= IO_BIT_LAST); // RQ1
                    bad    = !bit_wr;
                end
                OP_SKIP_IF_SET, OP_SKIP_IF_CLEAR: begin
                    bit_tst = (req_addr[5:0] <= IO_BIT_LAST); // RQ2
                    bad     = !bit_tst;
                end
                OP_DATA_LOAD, OP_DATA_STORE: begin
                    if (req_addr >= EXT_FIRST) begin
                        ext_rd = (req_op == OP_DATA_LOAD); // RQ7
                        ext_wr = (req_op == OP_DATA_STORE); // RQ7
                    end else if (req_addr >= DATA_IO_OFFSET) begin
                        io_idx = 6'(req_addr - DATA_IO_OFFSET); // RQ6
                        io_rd  = (req_op == OP_DATA_LOAD);
                        io_wr  = (req_op == OP_DATA_STORE);
                    end else begin
                        bad = 1'b1;
                    end
                end
                default: begin
                    bad = 1'b1;
                end
            endcase
        end
    end

    assign io_rd_data = io_reg[io_idx];
    assign bit_mask   = 8'h01 << req_bit;
    assign cur_bit    = io_rd_data[req_bit];

    // ==========================================================
    // Low I/O space next values
    always_comb begin
        for (int i = 0; i < IO_COUNT; i++) begin
            io_next[i] = io_reg[i];
        end
        if (io_wr) begin
            if (io_idx == FLAG_IO_ADDR) begin
                io_next[io_idx] = io_reg[io_idx] & ~req_wdata; // RQ3
            end else begin
                io_next[io_idx] = req_wdata;
            end
        end else if (bit_wr) begin
            if (io_idx == FLAG_IO_ADDR) begin
                // A set on a flag writes one to that bit only, which clears it
                if (req_op == OP_BIT_SET) begin
                    io_next[io_idx] = io_reg[io_idx] & ~bit_mask; // RQ4
                end
            end else if (req_op == OP_BIT_SET) begin
                io_next[io_idx] = io_reg[io_idx] | bit_mask; // RQ4
            end else begin
                io_next[io_idx] = io_reg[io_idx] & ~bit_mask; // RQ4
            end
        end
        // Hardware events win over a clear in the same cycle
        io_next[FLAG_IO_ADDR] = io_next[FLAG_IO_ADDR] | flag_set; // RQ3
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < IO_COUNT; i++) begin
                io_reg[i] <= IO_RESET_VAL;
            end
        end else begin
            for (int i = 0; i < IO_COUNT; i++) begin
                io_reg[i] <= io_next[i];
            end
        end
    end

    // ==========================================================
    // Extended bank
    iod_ext_bank u_ext (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (ext_wr),
        .addr     (req_addr),
        .wdata    (req_wdata),
        .rdata    (ext_rdata),
        .hit      (ext_hit),
        .regs_q   (ext_regs_q)
    );

    // ==========================================================
    // Response next values
    always_comb begin
        rsp_valid_next = req_valid;
        rsp_rdata_next = 8'h00;
        rsp_skip_next  = 1'b0;
        rsp_error_next = bad;
        if (io_rd) begin
            rsp_rdata_next = io_rd_data;
        end else if (ext_rd) begin
            rsp_rdata_next = ext_rdata; // RQ8
        end
        if (bit_tst) begin
            rsp_skip_next = (cur_bit == (req_op == OP_SKIP_IF_SET)); // RQ2
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 8'h00;
            rsp_skip_reg  <= 1'b0;
            rsp_error_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            rsp_skip_reg  <= rsp_skip_next;
            rsp_error_reg <= rsp_error_next;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign rsp_skip  = rsp_skip_reg;
    assign rsp_error = rsp_error_reg;
    assign flag_q    = io_reg[FLAG_IO_ADDR];

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_BIT_RANGE: assert property ( // RQ1
        req_valid && (req_op == OP_BIT_SET || req_op == OP_BIT_CLEAR) && req_addr[5:0] > IO_BIT_LAST
        |=> rsp_valid && rsp_error && io_reg[$past(io_idx)] == $past(io_rd_data))
        else $error("bit write above 0x1F not refused");
    AST_SKIP: assert property ( // RQ2
        req_valid && req_op == OP_SKIP_IF_CLEAR && req_addr[5:0] <= IO_BIT_LAST
        |=> rsp_skip == !$past(cur_bit))
        else $error("skip-if-clear answer wrong");
    AST_W1C: assert property ( // RQ3
        req_valid && req_op == OP_IO_WRITE && req_addr[5:0] == FLAG_IO_ADDR && flag_set == 8'h00
        |=> flag_q == ($past(flag_q) & ~$past(req_wdata)))
        else $error("flag write-one-to-clear wrong");
    AST_SET_WINS: assert property ( // RQ3
        flag_set != 8'h00 |=> (flag_q & $past(flag_set)) == $past(flag_set))
        else $error("hardware flag event lost");
    AST_BIT_ONLY: assert property ( // RQ4
        req_valid && req_op == OP_BIT_SET && req_addr[5:0] == FLAG_IO_ADDR && flag_set == 8'h00
        |=> flag_q == ($past(flag_q) & ~$past(bit_mask)))
        else $error("bit set disturbed other flags");
    AST_IO_READ: assert property ( // RQ5
        req_valid && req_op == OP_IO_READ |=> !rsp_error && rsp_rdata == $past(io_rd_data))
        else $error("I/O read data wrong");
    AST_DATA_MAP: assert property ( // RQ6
        req_valid && req_op == OP_DATA_LOAD && req_addr == (DATA_IO_OFFSET + 8'(FLAG_IO_ADDR))
        |=> rsp_rdata == $past(flag_q))
        else $error("data-space alias of I/O register wrong");
    AST_EXT_ONLY: assert property ( // RQ7
        !(req_valid && req_op == OP_DATA_STORE && req_addr >= EXT_FIRST) |=> $stable(ext_regs_q))
        else $error("extended bank changed by wrong access");
    AST_RSV_ZERO: assert property ( // RQ8
        req_valid && req_op == OP_DATA_LOAD && req_addr >= EXT_FIRST && !ext_hit
        |=> rsp_rdata == 8'h00)
        else $error("reserved location read nonzero");

endmodule
`default_nettype wire

// ==== bench/iod_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Processor core stand-in issuing one access per cycle
module iod_core_model (
    // Clock
    input  wire logic              core_clk,
    // Request toward the decoder
    output var  logic              req_valid,
    output var  iod_pkg::iod_op_t  req_op,
    output var  logic [7:0]        req_addr,
    output var  logic [2:0]        req_bit,
    output var  logic [7:0]        req_wdata
);
    import iod_pkg::*;

    // Quiet request lines from time zero
    initial begin
        req_valid = 1'b0;
        req_op    = OP_IO_READ;
        req_addr  = 8'h00;
        req_bit   = 3'h0;
        req_wdata = 8'h00;
    end

    // Launch at a falling edge, hold across the sampling rising edge
    task automatic access(input iod_op_t o, input logic [7:0] ad, input logic [2:0] b, input logic [7:0] wd);
        req_valid = 1'b1;
        req_op    = o;
        req_addr  = ad;
        req_bit   = b;
        req_wdata = wd;
        @(negedge core_clk);
    endtask

    // Released address and data lines invert, so stale values never pass for live ones
    task automatic release_bus();
        req_valid = 1'b0;
        req_addr  = ~req_addr;
        req_wdata = ~req_wdata;
        @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ==== bench/iod_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the I/O space decoder
module iod_decoder_tb;
    import iod_pkg::*;

    typedef struct packed { logic [7:0] rd; logic sk; logic er; } iod_exp_t;

    logic                core_clk;
    logic                rst;
    logic                req_valid;
    iod_op_t             req_op;
    logic [7:0]          req_addr;
    logic [2:0]          req_bit;
    logic [7:0]          req_wdata;
    logic                rsp_valid;
    logic [7:0]          rsp_rdata;
    logic                rsp_skip;
    logic                rsp_error;
    logic [7:0]          flag_set;
    logic [7:0]          flag_q;
    logic [EXT_COUNT*8-1:0] ext_regs_q;
    iod_exp_t            exp_q[$];
    iod_exp_t            e;
    int                  mismatches;
    int                  tests_run;
    logic [7:0]          a;
    logic [7:0]          d;

    iod_core_model u_core (.core_clk(core_clk), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata));

    iod_decoder u_dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip), .rsp_error(rsp_error),
        .flag_set(flag_set), .flag_q(flag_q), .ext_regs_q(ext_regs_q));

    // 20 MHz clock
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    // Single comparison point
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Note the expected response, then issue the access
    task automatic op(input iod_op_t o, input logic [7:0] ad, input logic [2:0] b, input logic [7:0] wd,
                      input logic [7:0] rd, input logic sk, input logic er);
        exp_q.push_back(iod_exp_t'{rd, sk, er});
        u_core.access(o, ad, b, wd);
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Response watcher takes the oldest note for each response
    always @(negedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("[ERR] response expected none seen one");
            end else begin
                e = exp_q.pop_front();
                check("rsp_rdata", rsp_rdata, e.rd);
                check("rsp_skip", {7'h00, rsp_skip}, {7'h00, e.sk});
                check("rsp_error", {7'h00, rsp_error}, {7'h00, e.er});
            end
        end
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        flag_set = 8'h00;
        mismatches = 0;
        tests_run = 0;
        void'($urandom(33));
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        // I/O and data-space aliases, back to back, upper address bits set on I/O writes
        for (int i = 0; i < 8; i++) begin
            a = (i < 2) ? 8'(i * 63) : 8'($urandom_range(62, 1));
            if (a == 8'h16) a = 8'h17;
            d = 8'($urandom);
            op(OP_IO_WRITE, {2'b11, a[5:0]}, 3'h0, d, 8'h00, 1'b0, 1'b0);
            op(OP_DATA_LOAD, a + DATA_IO_OFFSET, 3'h0, 8'h00, d, 1'b0, 1'b0);
            op(OP_DATA_STORE, a + DATA_IO_OFFSET, 3'h0, ~d, 8'h00, 1'b0, 1'b0);
            op(OP_IO_READ, a, 3'h0, 8'h00, ~d, 1'b0, 1'b0);
        end
        $display("test alias done");
        // Single-bit access at the last bit-reachable place and just above it
        op(OP_IO_WRITE, 8'h1F, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        for (int b = 0; b < 8; b++) begin
            op(OP_BIT_SET, 8'h1F, 3'(b), 8'h00, 8'h00, 1'b0, 1'b0);
            op(OP_SKIP_IF_CLEAR, 8'h1F, 3'(b), 8'h00, 8'h00, 1'b0, 1'b0);
        end
        for (int b = 0; b < 8; b++) begin
            op(OP_BIT_CLEAR, 8'h1F, 3'(b), 8'h00, 8'h00, 1'b0, 1'b0);
            op(OP_SKIP_IF_SET, 8'h1F, 3'(b), 8'h00, 8'h00, 1'b0, 1'b0);
            op(OP_SKIP_IF_CLEAR, 8'h1F, 3'(b), 8'h00, 8'h00, 1'b1, 1'b0);
            op(OP_IO_READ, 8'h1F, 3'h0, 8'h00, 8'(8'hFF << (b + 1)), 1'b0, 1'b0);
            op(OP_SKIP_IF_SET, 8'h1F, 3'(b + 1), 8'h00, 8'h00, b < 7, 1'b0);
        end
        op(OP_IO_WRITE, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        op(OP_BIT_SET, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
        op(OP_SKIP_IF_CLEAR, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
        op(OP_IO_READ, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        $display("test bit access done");
        // Write-one-to-clear flags with hardware events
        u_core.release_bus();
        flag_set = 8'hFF;
        @(negedge core_clk);
        flag_set = 8'h00;
        check("flag_q", flag_q, 8'hFF);
        op(OP_IO_WRITE, 8'(FLAG_IO_ADDR), 3'h0, 8'h05, 8'h00, 1'b0, 1'b0);
        op(OP_DATA_STORE, 8'h36, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        op(OP_BIT_SET, 8'(FLAG_IO_ADDR), 3'h7, 8'h00, 8'h00, 1'b0, 1'b0);
        op(OP_BIT_CLEAR, 8'(FLAG_IO_ADDR), 3'h1, 8'h00, 8'h00, 1'b0, 1'b0);
        flag_set = 8'h01;
        op(OP_IO_WRITE, 8'(FLAG_IO_ADDR), 3'h0, 8'h01, 8'h00, 1'b0, 1'b0);
        flag_set = 8'h00;
        op(OP_DATA_LOAD, 8'h36, 3'h0, 8'h00, 8'h7B, 1'b0, 1'b0);
        check("flag_q", flag_q, 8'h7B);
        $display("test flags done");
        // Extended space: data-space only, reserved bits and places read zero
        for (int i = 0; i < EXT_COUNT; i++) begin
            op(OP_DATA_STORE, EXT_ADDR[i], 3'h0, 8'hFF, 8'h00, 1'b0, 1'b0);
            op(OP_DATA_LOAD, EXT_ADDR[i], 3'h0, 8'h00, EXT_MASK[i], 1'b0, 1'b0);
            check("ext_regs_q", ext_regs_q[i*8+:8], EXT_MASK[i]);
        end
        op(OP_IO_WRITE, TWOWIRE_STATUS_PRESCALE_OFS, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        op(OP_DATA_STORE, 8'hB7, 3'h0, 8'hFF, 8'h00, 1'b0, 1'b0);
        op(OP_DATA_LOAD, 8'hB7, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        op(OP_DATA_LOAD, 8'hFF, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        op(OP_DATA_STORE, 8'h10, 3'h0, 8'hFF, 8'h00, 1'b0, 1'b1);
        op(OP_DATA_LOAD, 8'h1F, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
        check("ext_regs_q", ext_regs_q[2*8+:8], 8'hFB);
        u_core.release_bus();
        $display("test extended done");
        // Mid-run reset brings every register back to its reset value
        op(OP_IO_WRITE, 8'h3F, 3'h0, 8'hA5, 8'h00, 1'b0, 1'b0);
        u_core.release_bus();
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check("flag_q", flag_q, IO_RESET_VAL);
        check("ext_regs_q", ext_regs_q[12*8+:8], EXT_RESET_VAL);
        op(OP_IO_READ, 8'h3F, 3'h0, 8'h00, IO_RESET_VAL, 1'b0, 1'b0);
        op(OP_DATA_LOAD, SERIAL_DATA_OFS, 3'h0, 8'h00, EXT_RESET_VAL, 1'b0, 1'b0);
        u_core.release_bus();
        $display("test reset done");
        // Bounded drain of outstanding responses
        for (int w = 0; w < 4 && exp_q.size() != 0; w++) @(negedge core_clk);
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("[ERR] responses expected %0d seen 0", exp_q.size());
        end
        complete_run();
    end
endmodule
`default_nettype wire
